// ### src/ufac_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef UFAC_REGS_SVH
`define UFAC_REGS_SVH
`define UFAC_CTL_STATUS 1'h0
`define UFAC_CTL_CONTROL 1'h1
`define UFAC_CTRL_RESET 32'h01FFFFFF
`define UFAC_PAGE_MSB 19
`define UFAC_PAGE_LSB 0
`define UFAC_SEC_MSB 22
`define UFAC_SEC_LSB 20
`define UFAC_WP_LSB 23
`define UFAC_SP_LSB 25
`define UFAC_PAGE_NONE 20'hFFFFF
`define UFAC_SEC_NONE 3'h7
`define UFAC_SECTORS 3'h2
`define UFAC_ADDR_LIMIT 8'h80
`define UFAC_PAGE_LIMIT 20'h00080
`define UFAC_SEC_BIT 6
`define UFAC_PAGE_WORDS 8'h08
`define UFAC_SEC_WORDS 8'h40
`define UFAC_BURST_PAR 6'h01
`define UFAC_BURST_SER 6'h20
`define UFAC_ERASED 32'hFFFFFFFF
`define UFAC_BUSY_IDLE 2'h0
`define UFAC_BUSY_ERASE 2'h1
`define UFAC_BUSY_PROG 2'h2
`define UFAC_BUSY_READ 2'h3
`define UFAC_ST_RD_OK 2
`define UFAC_ST_WR_OK 3
`define UFAC_ST_ER_OK 4
`define UFAC_ERASE_MS 350
`define UFAC_CLK_MHZ 100
`define UFAC_PROG_CYCLES 32'h00000004
`define UFAC_H_ADDR 3'h0
`define UFAC_H_WDATA 3'h1
`define UFAC_H_CMD 3'h2
`define UFAC_H_STATUS 3'h3
`define UFAC_H_RDATA 3'h4
`define UFAC_CMD_WRITE 0
`define UFAC_CMD_CTL 1
`define UFAC_CMD_BURST_MSB 7
`define UFAC_CMD_BURST_LSB 2
`endif

// ### src/ufac_pkg.sv
// Types shared by both ends of the user flash controller link.
package ufac_pkg;
  typedef logic [31:0] ufac_word_t;
  typedef logic [1:0] ufac_busy_t;
  typedef logic [7:0] ufac_addr_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PROG = 4'b0010,
    ST_READ = 4'b0100,
    ST_ERASE = 4'b1000
  } ufac_state_e;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_DATA = 4'b0010,
    H_RVAL = 4'b0100,
    H_CTL = 4'b1000
  } ufac_hstate_e;
endpackage

// ### src/ufac_link_if.sv
// Control and data slave ports joining the master and the flash controller.
`timescale 1ns/1ps
`default_nettype none
interface ufac_link_if;
  logic ctl_addr;
  logic ctl_read;
  logic ctl_write;
  logic [31:0] ctl_wdata;
  logic [31:0] ctl_rdata;
  logic [7:0] dat_addr;
  logic dat_read;
  logic dat_write;
  logic [5:0] dat_burst;
  logic [31:0] dat_wdata;
  logic dat_wait;
  logic [31:0] dat_rdata;
  logic dat_rvalid;
  modport dev (
    input ctl_addr, ctl_read, ctl_write, ctl_wdata,
    output ctl_rdata,
    input dat_addr, dat_read, dat_write, dat_burst, dat_wdata,
    output dat_wait, dat_rdata, dat_rvalid
  );
  modport host (
    output ctl_addr, ctl_read, ctl_write, ctl_wdata,
    input ctl_rdata,
    output dat_addr, dat_read, dat_write, dat_burst, dat_wdata,
    input dat_wait, dat_rdata, dat_rvalid
  );
endinterface
`default_nettype wire

// ### src/ufac_flash_dev.sv
// Flash controller end: control and status registers, array and sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "ufac_regs.svh"
// Summary of operation
// - Separate control port and data port
// - Control read returns addressed register value
// - Control register written at address one
// - Program writes exactly one 32-bit word
// - Master clears write protection before program
// - Master gives legal address and burst count
// - Busy reads binary 10 while programming
// - Good program sets write success
// - Bad burst, address or protection clears it
// - Master restores write protection after program
// - Master checks status after each program
// - Control write with selection starts erase
// - Erase address accepted only while idle
// - Busy reads binary 01 while erasing
// - Data port waits during erase
// - Erase result recorded; up to 350 ms
// - Bad or protected sector erase fails
// - Illegal page erase address fails
// - Master brackets erase with protection changes
// - Master reads with legal address and burst
// - Waitrequest while busy, then readdatavalid with data
// - Busy reads binary 11 while reading
// - Read success flag; failures return erased data
module ufac_flash_dev #(
  parameter int unsigned ERASE_CYCLES = `UFAC_ERASE_MS * 1000 * `UFAC_CLK_MHZ
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Mode strap, high for serial burst rules
  input wire logic i_serial_mode,
  // Busy field mirror
  output var ufac_pkg::ufac_busy_t o_busy,
  // Link to the master
  ufac_link_if.dev link
);
  import ufac_pkg::*;

  ufac_word_t mem [0:`UFAC_ADDR_LIMIT-1];
  ufac_state_e state_q;
  ufac_state_e state_d;
  ufac_word_t ctrl_q;
  ufac_word_t ctl_rdata_q;
  ufac_word_t dat_rdata_q;
  ufac_busy_t busy_q;
  logic wait_q;
  logic rvalid_q;
  logic rd_ok_q;
  logic wr_ok_q;
  logic er_ok_q;
  logic pend_ok_q;
  ufac_addr_t op_addr_q;
  ufac_word_t op_data_q;
  ufac_addr_t er_len_q;
  logic [31:0] cnt_q;
  logic acc_rd;
  logic acc_wr;
  logic burst_ok;
  logic wr_legal;
  logic ctl_wr;
  logic sec_req;
  logic page_req;
  logic er_start;
  logic er_legal;
  logic prog_done;
  logic er_done;
  logic [2:0] new_sec;
  logic [19:0] new_page;

  function automatic ufac_busy_t busy_of(input ufac_state_e s);
    case (s)
      ST_PROG: busy_of = `UFAC_BUSY_PROG;
      ST_READ: busy_of = `UFAC_BUSY_READ;
      ST_ERASE: busy_of = `UFAC_BUSY_ERASE;
      default: busy_of = `UFAC_BUSY_IDLE;
    endcase
  endfunction

  // Sector or write protection bit set for the given sector.
  function automatic logic sec_blocked(input ufac_word_t c, input logic s);
    sec_blocked = c[`UFAC_WP_LSB + int'(s)] | c[`UFAC_SP_LSB + int'(s)];
  endfunction

  function automatic logic addr_ok(input ufac_addr_t a);
    addr_ok = a < `UFAC_ADDR_LIMIT;
  endfunction

  // Data commands are taken only while idle and not stalled.
  assign acc_rd = link.dat_read & ~wait_q & (state_q == ST_IDLE);
  assign acc_wr = link.dat_write & ~wait_q & (state_q == ST_IDLE);
  assign burst_ok = link.dat_burst ==
    (i_serial_mode ? `UFAC_BURST_SER : `UFAC_BURST_PAR);
  assign wr_legal = burst_ok & addr_ok(link.dat_addr) &
    ~sec_blocked(ctrl_q, link.dat_addr[`UFAC_SEC_BIT]);
  assign ctl_wr = link.ctl_write & (link.ctl_addr == `UFAC_CTL_CONTROL);
  assign new_sec = link.ctl_wdata[`UFAC_SEC_MSB:`UFAC_SEC_LSB];
  assign new_page = link.ctl_wdata[`UFAC_PAGE_MSB:`UFAC_PAGE_LSB];
  assign sec_req = new_sec != `UFAC_SEC_NONE;
  assign page_req = new_page != `UFAC_PAGE_NONE;
  // A data command taken in the same cycle has priority over an erase.
  assign er_start = ctl_wr & (sec_req | page_req) & ~acc_rd & ~acc_wr &
    (state_q == ST_IDLE);
  assign er_legal = sec_req ?
    ((new_sec < `UFAC_SECTORS) & ~sec_blocked(link.ctl_wdata, new_sec[0])) :
    (new_page < `UFAC_PAGE_LIMIT);
  assign prog_done = (state_q == ST_PROG) &
    (cnt_q == `UFAC_PROG_CYCLES - 32'h1);
  assign er_done = (state_q == ST_ERASE) && (cnt_q == ERASE_CYCLES - 1);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (acc_rd)
          state_d = ST_READ;
        else if (acc_wr && wr_legal)
          state_d = ST_PROG;
        else if (er_start && er_legal)
          state_d = ST_ERASE;
      end
      ST_PROG:
        if (prog_done)
          state_d = ST_IDLE;
      ST_READ:
        state_d = ST_IDLE;
      ST_ERASE:
        if (er_done)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Busy mirror and data-port stall follow the sequencer state.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      busy_q <= `UFAC_BUSY_IDLE;
      wait_q <= 1'b1;
    end
    else
    begin
      busy_q <= busy_of(state_d);
      wait_q <= state_d != ST_IDLE;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst || state_d != state_q)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_q + 32'h1;
  end

  // Operation address, data and erase span captured at acceptance.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      op_addr_q <= 8'h00;
      op_data_q <= 32'h0;
      er_len_q <= 8'h00;
      pend_ok_q <= 1'b0;
    end
    else if (acc_rd || acc_wr)
    begin
      op_addr_q <= link.dat_addr;
      op_data_q <= link.dat_wdata;
      pend_ok_q <= addr_ok(link.dat_addr) &
        ~sec_blocked(ctrl_q, link.dat_addr[`UFAC_SEC_BIT]);
    end
    else if (er_start)
    begin
      // Sector base is the sector number at the sector bit, not above it.
      op_addr_q <= sec_req ? {1'b0, new_sec[0], 6'h00} :
        {new_page[7:3], 3'h0};
      er_len_q <= sec_req ? `UFAC_SEC_WORDS : `UFAC_PAGE_WORDS;
    end
  end

  // Array: one program word at completion, erase walks one word a cycle.
  always_ff @(posedge i_clk)
  begin
    if (prog_done)
      mem[op_addr_q[6:0]] <= op_data_q;
    else if (state_q == ST_ERASE && cnt_q < {24'h0, er_len_q})
      mem[7'(op_addr_q + cnt_q[7:0])] <= `UFAC_ERASED;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      ctrl_q <= `UFAC_CTRL_RESET;
    else if (ctl_wr)
      ctrl_q <= link.ctl_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      wr_ok_q <= 1'b0;
    else if (acc_wr && !wr_legal)
      wr_ok_q <= 1'b0;
    else if (prog_done)
      wr_ok_q <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      er_ok_q <= 1'b0;
    else if (er_start && !er_legal)
      er_ok_q <= 1'b0;
    else if (er_done)
      er_ok_q <= 1'b1;
  end

  // Read answer: one cycle in the read state, then valid for one cycle.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rvalid_q <= 1'b0;
      dat_rdata_q <= 32'h0;
      rd_ok_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= state_q == ST_READ;
      if (state_q == ST_READ)
      begin
        dat_rdata_q <= pend_ok_q ? mem[op_addr_q[6:0]] : `UFAC_ERASED;
        rd_ok_q <= pend_ok_q;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst || !link.ctl_read)
      ctl_rdata_q <= 32'h0;
    else if (link.ctl_addr == `UFAC_CTL_CONTROL)
      ctl_rdata_q <= ctrl_q;
    else
      ctl_rdata_q <= {27'h0, er_ok_q, wr_ok_q, rd_ok_q,
        busy_of(state_q)};
  end

  assign link.ctl_rdata = ctl_rdata_q;
  assign link.dat_rdata = dat_rdata_q;
  assign link.dat_rvalid = rvalid_q;
  assign link.dat_wait = wait_q;
  assign o_busy = busy_q;
endmodule
`default_nettype wire

// ### src/ufac_flash_host.sv
// Bus master end: software command registers driving both slave ports.
`timescale 1ns/1ps
`default_nettype none
`include "ufac_regs.svh"
module ufac_flash_host (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Software register port
  input wire logic [2:0] i_sw_addr,
  input wire ufac_pkg::ufac_word_t i_sw_wdata,
  input wire logic i_sw_wr,
  input wire logic i_sw_rd,
  output var ufac_pkg::ufac_word_t o_sw_rdata,
  // Link to the controller
  ufac_link_if.host link
);
  import ufac_pkg::*;

  ufac_hstate_e state_q;
  ufac_addr_t addr_q;
  ufac_word_t wdata_q;
  ufac_word_t rdata_q;
  ufac_word_t sw_rdata_q;
  logic [5:0] burst_q;
  logic ctl_read_q;
  logic ctl_write_q;
  logic dat_read_q;
  logic dat_write_q;
  logic go;

  // A command is ignored while the previous one is still running.
  assign go = i_sw_wr && i_sw_addr == `UFAC_H_CMD && state_q == H_IDLE;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      addr_q <= 8'h00;
      wdata_q <= 32'h0;
    end
    else if (i_sw_wr && i_sw_addr == `UFAC_H_ADDR)
      addr_q <= i_sw_wdata[7:0];
    else if (i_sw_wr && i_sw_addr == `UFAC_H_WDATA)
      wdata_q <= i_sw_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_q <= H_IDLE;
      ctl_read_q <= 1'b0;
      ctl_write_q <= 1'b0;
      dat_read_q <= 1'b0;
      dat_write_q <= 1'b0;
      burst_q <= `UFAC_BURST_PAR;
      rdata_q <= 32'h0;
    end
    else
    begin
      ctl_read_q <= 1'b0;
      ctl_write_q <= 1'b0;
      case (state_q)
        H_IDLE:
          if (go)
          begin
            burst_q <= i_sw_wdata[`UFAC_CMD_BURST_MSB:`UFAC_CMD_BURST_LSB];
            if (i_sw_wdata[`UFAC_CMD_CTL])
            begin
              // Protection changes travel as control writes.
              ctl_write_q <= i_sw_wdata[`UFAC_CMD_WRITE];
              ctl_read_q <= ~i_sw_wdata[`UFAC_CMD_WRITE];
              state_q <= i_sw_wdata[`UFAC_CMD_WRITE] ? H_IDLE : H_CTL;
            end
            else
            begin
              dat_write_q <= i_sw_wdata[`UFAC_CMD_WRITE];
              dat_read_q <= ~i_sw_wdata[`UFAC_CMD_WRITE];
              state_q <= H_DATA;
            end
          end
        H_DATA:
          if (!link.dat_wait)
          begin
            dat_read_q <= 1'b0;
            dat_write_q <= 1'b0;
            state_q <= dat_read_q ? H_RVAL : H_IDLE;
          end
        H_RVAL:
          if (link.dat_rvalid)
          begin
            rdata_q <= link.dat_rdata;
            state_q <= H_IDLE;
          end
        // Control read data stand only in the cycle after the strobe.
        H_CTL:
          if (!ctl_read_q)
          begin
            rdata_q <= link.ctl_rdata;
            state_q <= H_IDLE;
          end
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst || !i_sw_rd)
      sw_rdata_q <= 32'h0;
    else
      case (i_sw_addr)
        `UFAC_H_ADDR: sw_rdata_q <= {24'h0, addr_q};
        `UFAC_H_WDATA: sw_rdata_q <= wdata_q;
        `UFAC_H_STATUS: sw_rdata_q <= {31'h0, state_q != H_IDLE};
        `UFAC_H_RDATA: sw_rdata_q <= rdata_q;
        default: sw_rdata_q <= 32'h0;
      endcase
  end

  assign link.ctl_addr = addr_q[0];
  assign link.ctl_read = ctl_read_q;
  assign link.ctl_write = ctl_write_q;
  assign link.ctl_wdata = wdata_q;
  assign link.dat_addr = addr_q;
  assign link.dat_read = dat_read_q;
  assign link.dat_write = dat_write_q;
  assign link.dat_burst = burst_q;
  assign link.dat_wdata = wdata_q;
  assign o_sw_rdata = sw_rdata_q;
endmodule
`default_nettype wire

// ### testbench/ufac_link_chk.sv
// Checker watching the link between the master and controller ends.
`timescale 1ns/1ps
`default_nettype none
module ufac_link_chk #(
  parameter int unsigned ERASE_CYCLES = 100
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Busy mirror and link signals
  input wire ufac_pkg::ufac_busy_t o_busy,
  input wire logic ctl_addr,
  input wire logic ctl_read,
  input wire logic [31:0] ctl_rdata,
  input wire logic [7:0] dat_addr,
  input wire logic dat_read,
  input wire logic dat_wait,
  input wire logic [31:0] dat_rdata,
  input wire logic dat_rvalid
);
  import ufac_pkg::*;
  logic [31:0] er_cnt_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Counts the cycles of the erase in progress.
  always_ff @(posedge i_clk)
  begin
    if (i_srst || o_busy != 2'h1)
      er_cnt_q <= 32'h0;
    else
      er_cnt_q <= er_cnt_q + 32'h1;
  end
  property p_ctl_idle;
    !ctl_read |=> ctl_rdata == 32'h0;
  endproperty
  a_ctl_idle: assert property (p_ctl_idle)
    else $error("control read data not cleared");
  property p_st_busy;
    ctl_read && !ctl_addr |=> ctl_rdata[1:0] == $past(o_busy);
  endproperty
  a_st_busy: assert property (p_st_busy)
    else $error("status busy field wrong");
  property p_rd_seq;
    dat_read && !dat_wait && o_busy == 2'h0 |=> dat_wait && o_busy == 2'h3
      ##1 dat_rvalid && o_busy == 2'h0;
  endproperty
  a_rd_seq: assert property (p_rd_seq)
    else $error("read sequence wrong");
  property p_rd_erased;
    dat_read && !dat_wait && o_busy == 2'h0 && dat_addr >= 8'h80
      |-> ##2 dat_rdata == 32'hFFFFFFFF;
  endproperty
  a_rd_erased: assert property (p_rd_erased)
    else $error("illegal read not erased data");
  property p_rv_pulse;
    dat_rvalid |=> !dat_rvalid;
  endproperty
  a_rv_pulse: assert property (p_rv_pulse)
    else $error("read valid longer than one cycle");
  property p_prog_len;
    o_busy == 2'h2 && $past(o_busy) != 2'h2
      |-> (o_busy == 2'h2 && dat_wait)[*4] ##1 o_busy == 2'h0;
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("program busy span wrong");
  property p_erase_wait;
    o_busy == 2'h1 |-> dat_wait;
  endproperty
  a_erase_wait: assert property (p_erase_wait)
    else $error("data port not stalled in erase");
  property p_erase_len;
    $past(o_busy) == 2'h1 && o_busy != 2'h1
      |-> er_cnt_q == ERASE_CYCLES && o_busy == 2'h0;
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase busy span wrong");
  property p_erase_gate;
    o_busy[1] |=> o_busy != 2'h1;
  endproperty
  a_erase_gate: assert property (p_erase_gate)
    else $error("erase started while busy");
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench driving both controller ends through software.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ufac_pkg::*;
  localparam int unsigned ERASE_N = 100;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic serial = 1'b0;
  logic [2:0] h_addr = 3'h0;
  ufac_word_t h_wdata = 32'h0;
  logic h_wr = 1'b0;
  logic h_rd = 1'b0;
  ufac_word_t h_rdata;
  ufac_busy_t busy;
  int miscompares = 0;
  int cmp_count = 0;
  ufac_word_t v;
  ufac_link_if link ();
  always #5 i_clk = ~i_clk;
  ufac_flash_dev #(.ERASE_CYCLES(ERASE_N)) ufac_flash_dev_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_serial_mode(serial),
    .o_busy(busy), .link(link));
  ufac_flash_host ufac_flash_host_inst (
    .i_clk(i_clk), .i_srst(i_srst), .i_sw_addr(h_addr),
    .i_sw_wdata(h_wdata), .i_sw_wr(h_wr), .i_sw_rd(h_rd),
    .o_sw_rdata(h_rdata), .link(link));
  ufac_link_chk #(.ERASE_CYCLES(ERASE_N)) ufac_link_chk_inst (
    .i_clk(i_clk), .i_srst(i_srst), .o_busy(busy),
    .ctl_addr(link.ctl_addr), .ctl_read(link.ctl_read),
    .ctl_rdata(link.ctl_rdata), .dat_addr(link.dat_addr),
    .dat_read(link.dat_read), .dat_wait(link.dat_wait),
    .dat_rdata(link.dat_rdata), .dat_rvalid(link.dat_rvalid));
  task automatic chk(input ufac_word_t got, input ufac_word_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sw_write(input logic [2:0] a, input ufac_word_t d);
    @(posedge i_clk);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge i_clk);
    h_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [2:0] a, output ufac_word_t d);
    @(posedge i_clk);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge i_clk);
    h_rd <= 1'b0;
    #1 d = h_rdata;
  endtask
  // Loads address, data and command, then polls until the host is idle.
  task automatic op(input ufac_word_t a, input ufac_word_t d,
                    input ufac_word_t c);
    int n;
    sw_write(3'h0, a);
    sw_write(3'h1, d);
    sw_write(3'h2, c);
    repeat (2) @(posedge i_clk);
    v = 32'h1;
    n = 0;
    while (v[0] !== 1'b0 && n < 400)
    begin
      sw_read(3'h3, v);
      n++;
    end
    if (n >= 400)
      miscompares++;
  endtask
  task automatic stat(output ufac_word_t s);
    op(32'h0, 32'h0, 32'h2);
    sw_read(3'h4, s);
  endtask
  task automatic ctl_wr(input ufac_word_t d);
    op(32'h1, d, 32'h3);
  endtask
  task automatic rd_word(input ufac_word_t a, input ufac_word_t exp);
    ufac_word_t s;
    op(a, 32'h0, 32'h4);
    sw_read(3'h4, s);
    chk(s, exp);
  endtask
  task automatic flag(input int k, input logic b);
    ufac_word_t s;
    stat(s);
    chk({31'h0, s[k]}, {31'h0, b});
  endtask
  task automatic dwait();
    ufac_word_t s;
    int n;
    s = 32'h1;
    n = 0;
    while (s[1:0] !== 2'h0 && n < 100)
    begin
      stat(s);
      n++;
    end
    if (n >= 100)
      miscompares++;
  endtask
  task automatic t_reset();
    ufac_word_t s;
    op(32'h1, 32'h0, 32'h2);
    sw_read(3'h4, s);
    chk(s, 32'h01FFFFFF);
    stat(s);
    chk(s, 32'h0);
  endtask
  task automatic t_sector_prog();
    ufac_word_t s;
    ctl_wr(32'h007FFFFF);
    ctl_wr(32'h000FFFFF);
    stat(s);
    chk({30'h0, s[1:0]}, 32'h1);
    dwait();
    flag(4, 1'b1);
    rd_word(32'h10, 32'hFFFFFFFF);
    flag(2, 1'b1);
    op(32'h10, 32'hA5C30F1E, 32'h5);
    dwait();
    flag(3, 1'b1);
    rd_word(32'h10, 32'hA5C30F1E);
    ctl_wr(32'h017FFFFF);
    op(32'h50, 32'h1234ABCD, 32'h5);
    flag(3, 1'b0);
    op(32'h11, 32'h00C0FFEE, 32'h5);
    dwait();
    flag(3, 1'b1);
    op(32'h12, 32'h00C0FFEE, 32'h9);
    flag(3, 1'b0);
    rd_word(32'h80, 32'hFFFFFFFF);
    flag(2, 1'b0);
  endtask
  task automatic t_erase_busy();
    ctl_wr(32'h007FFFFF);
    op(32'h50, 32'h1234ABCD, 32'h5);
    dwait();
    ctl_wr(32'h00700010);
    ctl_wr(32'h001FFFFF);
    rd_word(32'h10, 32'hFFFFFFFF);
    rd_word(32'h50, 32'h1234ABCD);
    ctl_wr(32'h002FFFFF);
    flag(4, 1'b0);
    ctl_wr(32'h00700018);
    dwait();
    flag(4, 1'b1);
    ctl_wr(32'h00700080);
    flag(4, 1'b0);
  endtask
  task automatic t_serial();
    @(posedge i_clk);
    serial <= 1'b1;
    op(32'h20, 32'h0BADF00D, 32'h5);
    flag(3, 1'b0);
    op(32'h20, 32'h0BADF00D, 32'h81);
    dwait();
    flag(3, 1'b1);
    ctl_wr(32'h001FFFFF);
    dwait();
    flag(4, 1'b1);
    @(posedge i_clk);
    serial <= 1'b0;
    rd_word(32'h50, 32'hFFFFFFFF);
    rd_word(32'h20, 32'h0BADF00D);
    ctl_wr(32'h01FFFFFF);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge i_clk);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_sector_prog();
    t_erase_busy();
    t_serial();
    print_verdict();
  end
endmodule
`default_nettype wire
